// >>> gcm_global_ctrl.sv
// Functional notes
// R01: Writing one to an action bit triggers that action; zero does nothing.
// R02: Action register at 0x3E/0x3F is write-only, volatile, reads back zero.
// R03: Bit 4 clears all status alarm and error flags once per write.
// R04: Bit 3 copies nonvolatile registers to flash, allowing 50 ms.
// R05: Bit 2 loads stored DAC word into the DAC; byte writes do not.
// R06: Host writes both DAC bytes before issuing the latch action.
// R07: Bit 1 zeroes tilt offset, clears averaging filter, then stores flash.
// R08: Bit 0 loads offset that zeroes present tilt, then stores flash.
// R09: Misc control routes, enables and sets polarity of data-ready pin.
// R10: Data-ready returns inactive partway through the next conversion cycle.
// R11: Data-ready goes active when each processing cycle completes.
// R12: Pin priority: misc control, then alarm control, then general pin control.
// R13: Misc control offers reversal of the tilt rotation sense.
// R14: Self-test runs a diagnostic and reports pass/fail in status bit 5.
// R15: During self-test the tilt outputs show nominal 37 degrees.
// R16: Self-test borrows sample period and restores the original afterwards.
// R17: Misc bit 9 reverses both tilt outputs; clear means normal rotation. The code has one tilt output, tilt_out_o.
// R18: Data-ready config is nonvolatile; self-test bit clears on reset.
// R19: Bit 7 soft-resets the device; bits 15:8 and 6:5 are ignored.
// R20: Several action bits run in turn; flash stores never overlap.
`timescale 1ns/1ps
`default_nettype none
module gcm_global_ctrl
    import gcm_pkg::*;
#(
    parameter int FLASH_CYC = gcm_pkg::GCM_FLASH_CYC
)(
    input  wire logic              mclk_i,          // 40 MHz system clock
    input  wire logic              nrst_i,          // Sync reset, active low
    input  wire gcm_pkg::gcm_wr_t  bus_i,           // Byte write from SPI decoder
    input  wire logic [15:0]       misc_nv_i,       // Misc control restored from flash
    input  wire logic [15:0]       dac_word_i,      // Stored DAC register word
    input  wire logic [13:0]       tilt_raw_i,      // Raw tilt angle
    input  wire logic              sample_done_i,   // Processing cycle complete pulse
    input  wire logic [7:0]        sample_period_i, // Current sample-period setting
    input  wire logic              st_done_i,       // Self-test finished pulse
    input  wire logic              st_fail_i,       // Self-test verdict with done
    input  wire logic [1:0]        alarm_pin_en_i,  // Alarm control claims per pin
    input  wire logic [1:0]        alarm_pin_val_i, // Alarm levels per pin
    input  wire logic [1:0]        gpio_out_i,      // General pin control levels
    output logic [15:0]            misc_reg_o,      // Misc control readback
    output logic [11:0]            dac_out_o,       // Word latched into DAC
    output logic [15:0]            tilt_offset_o,   // Tilt offset trim
    output logic [13:0]            tilt_out_o,      // Processed tilt output
    output logic                   status_clr_o,    // Clear status flags pulse
    output logic                   st_fail_o,       // Status bit 5 value
    output logic                   filt_clr_o,      // Averaging filter clear pulse
    output logic                   flash_busy_o,    // Flash store in progress
    output logic                   soft_rst_o,      // Software reset pulse
    output logic [7:0]             sample_period_o, // Override of sample period
    output logic                   sample_ovr_o,    // Override valid
    output logic [1:0]             pin_o            // General-purpose pin levels
);
    localparam logic [7:0] ST_PERIOD = 8'h01;

    gcm_state_t  state_reg, state_next;
    logic [4:0]  pend_reg;
    logic [15:0] misc_reg;
    logic [15:0] off_reg;
    logic [31:0] cnt_reg;
    logic [15:0] period_cnt_reg, period_len_reg;
    logic        dr_reg, st_fail_reg, st_run_reg, busy_reg;
    logic [7:0]  saved_period_reg, period_out_reg;
    logic [1:0]  pin_reg;
    logic [13:0] tilt_reg;
    logic [11:0] dac_reg;
    logic        clr_reg, fclr_reg, srst_reg;

    // Byte decodes; the action register has no storage, so reads see zero
    wire act_wr   = bus_i.wr && (bus_i.addr == GCM_ADDR_ACTION_LO); // R02
    wire misc_lo  = bus_i.wr && (bus_i.addr == GCM_ADDR_MISC_LO);
    wire misc_hi  = bus_i.wr && (bus_i.addr == GCM_ADDR_MISC_HI);
    wire [7:0] a  = act_wr ? bus_i.data : 8'h00; // R01
    // High byte at 0x3F holds only unused bits, ignored
    wire st_req   = misc_hi && bus_i.data[GCM_MISC_ST_EN-8];
    wire [13:0] tilt_adj = tilt_raw_i - off_reg[13:0];
    wire [13:0] tilt_rot = misc_reg[GCM_MISC_REV] ? (14'h0000 - tilt_adj) : tilt_adj; // R13 R17
    wire dr_level = dr_reg ~^ misc_reg[GCM_MISC_DR_POL];
    wire [15:0] dr_off_at = 16'((32'(period_len_reg) * GCM_DR_LOW_PCT) / 100);
    wire flash_end = (state_reg == GCM_BUSY) && (cnt_reg == 32'(FLASH_CYC - 1));

    // Action sequencer: null, then factory, each followed by its own flash store
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            GCM_IDLE:  if (pend_reg[GCM_BIT_NULL]) state_next = GCM_NULL;
                       else if (pend_reg[GCM_BIT_FACT]) state_next = GCM_FACT;
                       else if (pend_reg[GCM_BIT_FLASH]) state_next = GCM_FLASH;
            GCM_NULL:  state_next = GCM_FLASH; // R08
            GCM_FACT:  state_next = GCM_FLASH; // R07
            GCM_FLASH: state_next = GCM_BUSY;
            GCM_BUSY:  if (flash_end) state_next = GCM_IDLE; // R20
            default:   state_next = GCM_IDLE;
        endcase
    end

    // Pending actions; new requests win over the clear of a served one
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i || srst_reg)
        begin
            state_reg <= GCM_IDLE;
            pend_reg  <= 5'h00;
            cnt_reg   <= 32'h0000_0000;
            busy_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            busy_reg  <= (state_next == GCM_BUSY); // R04
            pend_reg[GCM_BIT_NULL]  <= a[GCM_BIT_NULL] | (pend_reg[GCM_BIT_NULL] & (state_reg != GCM_NULL));
            pend_reg[GCM_BIT_FACT]  <= a[GCM_BIT_FACT] | (pend_reg[GCM_BIT_FACT] &
                                       !(state_reg == GCM_FACT || (state_reg == GCM_IDLE && pend_reg[0] == 1'b0)));
            pend_reg[GCM_BIT_FLASH] <= a[GCM_BIT_FLASH] | (pend_reg[GCM_BIT_FLASH] & (state_reg != GCM_FLASH)); // R04 R20
            // Latch and clear act at once and never queue
            pend_reg[GCM_BIT_DACLAT] <= 1'b0;
            pend_reg[GCM_BIT_CLRST]  <= 1'b0;
            cnt_reg <= (state_reg == GCM_BUSY) ? cnt_reg + 32'h1 : 32'h0000_0000; // R04
        end
    end

    // Offset trim, DAC latch and one-cycle command pulses
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            off_reg  <= GCM_OFFSET_RST;
            dac_reg  <= 12'h000;
            clr_reg  <= 1'b0;
            fclr_reg <= 1'b0;
            srst_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == GCM_NULL)
                off_reg <= {2'b00, tilt_raw_i}; // R08
            else if (state_reg == GCM_FACT)
                off_reg <= GCM_OFFSET_RST; // R07
            if (a[GCM_BIT_DACLAT])
                dac_reg <= dac_word_i[11:0]; // R05
            clr_reg  <= a[GCM_BIT_CLRST]; // R03
            fclr_reg <= (state_reg == GCM_FACT); // R07
            srst_reg <= a[GCM_BIT_SWRST]; // R19
        end
    end

    // Misc control: config reloads from flash image, self-test bit cleared
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i || srst_reg)
            misc_reg <= misc_nv_i & ~(16'h0001 << GCM_MISC_ST_EN); // R18
        else
        begin
            if (misc_lo)
                misc_reg[7:0] <= bus_i.data;
            if (misc_hi)
                misc_reg[15:8] <= bus_i.data;
            if (st_done_i && st_run_reg)
                misc_reg[GCM_MISC_ST_EN] <= 1'b0;
        end
    end

    // Self-test borrows the sample period and hands it back when done
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i || srst_reg)
        begin
            st_run_reg       <= 1'b0;
            st_fail_reg      <= 1'b0;
            saved_period_reg <= 8'h00;
            period_out_reg   <= 8'h00;
        end
        else if (st_req && !st_run_reg)
        begin
            st_run_reg       <= 1'b1;
            saved_period_reg <= sample_period_i; // R16
            period_out_reg   <= ST_PERIOD; // R16
        end
        else if (st_done_i && st_run_reg)
        begin
            st_run_reg     <= 1'b0;
            st_fail_reg    <= st_fail_i; // R14
            period_out_reg <= saved_period_reg; // R16
        end
        else if (clr_reg)
            st_fail_reg <= 1'b0; // R03
    end

    // Data-ready: active at end of processing, inactive a share into next period
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
        begin
            dr_reg         <= 1'b0;
            period_cnt_reg <= 16'h0000;
            period_len_reg <= 16'hFFFF;
        end
        else if (sample_done_i)
        begin
            dr_reg         <= 1'b1; // R11
            period_len_reg <= period_cnt_reg;
            period_cnt_reg <= 16'h0000;
        end
        else
        begin
            if (period_cnt_reg != 16'hFFFF)
                period_cnt_reg <= period_cnt_reg + 16'h0001;
            if (period_cnt_reg >= dr_off_at)
                dr_reg <= 1'b0; // R10
        end
    end

    // Pin mux: misc control beats alarm control beats general control
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_pin
            wire misc_claim = misc_reg[GCM_MISC_DR_EN] && (misc_reg[GCM_MISC_DR_SEL] == 1'(p)); // R09
            always_ff @(posedge mclk_i)
            begin
                if (!nrst_i)
                    pin_reg[p] <= 1'b0;
                else if (misc_claim)
                    pin_reg[p] <= dr_level; // R12
                else if (alarm_pin_en_i[p])
                    pin_reg[p] <= alarm_pin_val_i[p];
                else
                    pin_reg[p] <= gpio_out_i[p];
            end
        end
    endgenerate

    // Output angle: fixed 37 degrees while self-test runs
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i)
            tilt_reg <= 14'h0000;
        else
            tilt_reg <= st_run_reg ? GCM_ST_ANGLE : tilt_rot; // R15
    end

    assign misc_reg_o      = misc_reg;
    assign dac_out_o       = dac_reg;
    assign tilt_offset_o   = off_reg;
    assign tilt_out_o      = tilt_reg;
    assign status_clr_o    = clr_reg;
    assign st_fail_o       = st_fail_reg;
    assign filt_clr_o      = fclr_reg;
    assign flash_busy_o    = busy_reg;
    assign soft_rst_o      = srst_reg;
    assign sample_period_o = period_out_reg; // R16
    assign sample_ovr_o    = st_run_reg;
    assign pin_o           = pin_reg;
endmodule
`default_nettype wire

// >>> gcm_pkg.sv
package gcm_pkg;
    // Register byte addresses
    localparam logic [5:0]  GCM_ADDR_ACTION_LO = 6'h3E;
    localparam logic [5:0]  GCM_ADDR_ACTION_HI = 6'h3F;
    localparam logic [5:0]  GCM_ADDR_MISC_LO   = 6'h34;
    localparam logic [5:0]  GCM_ADDR_MISC_HI   = 6'h35;
    // Action bit positions
    localparam int GCM_BIT_NULL   = 0;
    localparam int GCM_BIT_FACT   = 1;
    localparam int GCM_BIT_DACLAT = 2;
    localparam int GCM_BIT_FLASH  = 3;
    localparam int GCM_BIT_CLRST  = 4;
    localparam int GCM_BIT_SWRST  = 7;
    // Misc control bit positions
    localparam int GCM_MISC_DR_SEL = 0;
    localparam int GCM_MISC_DR_POL = 1;
    localparam int GCM_MISC_DR_EN  = 2;
    localparam int GCM_MISC_ST_EN  = 8;
    localparam int GCM_MISC_REV    = 9;
    // Reset values
    localparam logic [15:0] GCM_ACTION_RST = 16'h0000;
    localparam logic [15:0] GCM_MISC_RST   = 16'h0000;
    localparam logic [15:0] GCM_OFFSET_RST = 16'h0000;
    localparam logic [13:0] GCM_ST_ANGLE   = 14'h05C8; // 37 deg at 0.025 deg/LSB
    // Timing
    localparam int GCM_CLK_HZ     = 40000000;
    localparam int GCM_FLASH_MS   = 50;
    localparam int GCM_FLASH_CYC  = GCM_CLK_HZ / 1000 * GCM_FLASH_MS;
    localparam int GCM_DR_LOW_PCT = 25;   // Data-ready active share of a sample period

    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } gcm_wr_t;

    typedef enum logic [2:0] {
        GCM_IDLE  = 3'b000,
        GCM_NULL  = 3'b001,
        GCM_FACT  = 3'b010,
        GCM_FLASH = 3'b011,
        GCM_BUSY  = 3'b100
    } gcm_state_t;
endpackage

// >>> gcm_global_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gcm_global_ctrl_properties
    import gcm_pkg::*;
#(
    parameter int FLASH_CYC = 20
)(
    input wire logic             mclk_i,          // Clock
    input wire logic             nrst_i,          // Sync reset
    input wire gcm_pkg::gcm_wr_t bus_i,           // Byte write
    input wire logic [15:0]      dac_word_i,      // Stored DAC word
    input wire logic [13:0]      tilt_raw_i,      // Raw tilt
    input wire logic             st_done_i,       // Self-test end
    input wire logic             st_fail_i,       // Self-test verdict
    input wire logic [11:0]      dac_out_o,       // DAC word
    input wire logic [15:0]      tilt_offset_o,   // Offset trim
    input wire logic             status_clr_o,    // Clear pulse
    input wire logic             filt_clr_o,      // Filter clear pulse
    input wire logic             st_fail_o,       // Fail flag
    input wire logic             flash_busy_o,    // Store running
    input wire logic             soft_rst_o,      // Soft reset pulse
    input wire logic [7:0]       sample_period_o, // Period override
    input wire logic             sample_ovr_o     // Override valid
);
    logic [2:0]  quiet_reg;
    logic [31:0] busy_cnt_reg;
    wire logic   act_w = bus_i.wr && bus_i.addr == GCM_ADDR_ACTION_LO;

    default clocking dcb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // Fixed latencies only hold from idle, so count quiet cycles
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i || act_w || flash_busy_o || soft_rst_o)
            quiet_reg <= 3'h0;
        else if (quiet_reg != 3'h7)
            quiet_reg <= quiet_reg + 3'h1;
    end

    // Length of the running store
    always_ff @(posedge mclk_i)
    begin
        if (!nrst_i || !flash_busy_o)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end

    sequence s_idle_cmd(logic [7:0] v);
        act_w && bus_i.data == v && quiet_reg >= 3'h4;
    endsequence

    a_clear_status_pulse: assert property (act_w && bus_i.data[GCM_BIT_CLRST] |=> status_clr_o)
        else $error("clear pulse missing");
    a_no_spurious_clear: assert property (!(act_w && bus_i.data[GCM_BIT_CLRST]) |=> !status_clr_o)
        else $error("clear pulse without command");
    a_soft_reset_pulse: assert property (act_w && bus_i.data[GCM_BIT_SWRST] |=> soft_rst_o)
        else $error("soft reset pulse missing");
    a_dac_latch_load: assert property (act_w && bus_i.data[GCM_BIT_DACLAT] |=> dac_out_o == $past(dac_word_i[11:0]))
        else $error("DAC not latched");
    a_dac_byte_hold: assert property (!(act_w && (bus_i.data[GCM_BIT_DACLAT] || bus_i.data[GCM_BIT_SWRST]))
        && !soft_rst_o |=> $stable(dac_out_o)) else $error("DAC moved without latch");
    a_flash_store_start: assert property (s_idle_cmd(8'h08) |-> ##3 flash_busy_o)
        else $error("store did not start");
    a_flash_store_length: assert property ($fell(flash_busy_o) |-> busy_cnt_reg == FLASH_CYC)
        else $error("store length wrong");
    a_null_then_store: assert property (s_idle_cmd(8'h01) |-> ##3 tilt_offset_o == 16'($past(tilt_raw_i))
        ##1 flash_busy_o) else $error("null sequence wrong");
    a_factory_then_store: assert property (s_idle_cmd(8'h02) |-> ##3 tilt_offset_o == GCM_OFFSET_RST
        && filt_clr_o ##1 flash_busy_o) else $error("factory sequence wrong");
    a_selftest_period: assert property (sample_ovr_o |-> sample_period_o == 8'h01)
        else $error("override period wrong");
    a_selftest_verdict: assert property (st_done_i && st_fail_i && sample_ovr_o && !act_w |=> st_fail_o)
        else $error("fail verdict lost");
endmodule

bind gcm_global_ctrl gcm_global_ctrl_properties #(.FLASH_CYC(FLASH_CYC)) u_chk (.mclk_i, .nrst_i, .bus_i,
    .dac_word_i, .tilt_raw_i, .st_done_i, .st_fail_i, .dac_out_o, .tilt_offset_o, .status_clr_o, .filt_clr_o, .st_fail_o,
    .flash_busy_o, .soft_rst_o, .sample_period_o, .sample_ovr_o);
`default_nettype wire

// >>> gcm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module gcm_host_model
    import gcm_pkg::*;
(
    input  wire logic             mclk_i, // Clock
    output var gcm_pkg::gcm_wr_t  bus_o   // Byte write to device
);
    initial bus_o = '0;

    // One byte per write; released lines show inverted data
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input int gap = 0);
        repeat (gap) @(negedge mclk_i);
        @(negedge mclk_i);
        bus_o = '{wr: 1'b1, addr: a, data: d};
        @(negedge mclk_i);
        bus_o = '{wr: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule
`default_nettype wire

// >>> global_command_and_misc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module global_command_and_misc_control_tb;
    import gcm_pkg::*;
    localparam int FLASH = 20;
    logic mclk_i, nrst_i, sample_done_i, st_done_i, st_fail_i, status_clr_o, st_fail_o, filt_clr_o;
    logic flash_busy_o, soft_rst_o, sample_ovr_o;
    logic [15:0] misc_nv_i, dac_word_i, misc_reg_o, tilt_offset_o;
    logic [13:0] tilt_raw_i, tilt_out_o;
    logic [11:0] dac_out_o, prev;
    logic [7:0]  sample_period_i, sample_period_o;
    logic [1:0]  alarm_pin_en_i, alarm_pin_val_i, gpio_out_i, pin_o;
    gcm_wr_t     bus_i;
    int          n_errors, check_count, n;

    gcm_host_model host (.mclk_i, .bus_o(bus_i));
    gcm_global_ctrl #(.FLASH_CYC(FLASH)) dut (.mclk_i, .nrst_i, .bus_i, .misc_nv_i, .dac_word_i, .tilt_raw_i,
        .sample_done_i, .sample_period_i, .st_done_i, .st_fail_i, .alarm_pin_en_i, .alarm_pin_val_i, .gpio_out_i,
        .misc_reg_o, .dac_out_o, .tilt_offset_o, .tilt_out_o, .status_clr_o, .st_fail_o, .filt_clr_o,
        .flash_busy_o, .soft_rst_o, .sample_period_o, .sample_ovr_o, .pin_o);

    function automatic logic [15:0] exp_misc(input logic [15:0] nv);
        return nv & 16'hFEFF;
    endfunction
    function automatic logic [13:0] exp_tilt(input logic [13:0] raw, input logic rev);
        return rev ? 14'(-raw) : raw;
    endfunction

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk_i);
    endtask
    // Counts busy cycles of one store, bounded so a hang cannot stall
    task automatic store_len(output int c);
        c = 0;
        for (int i = 0; i < 200 && (c == 0 || flash_busy_o); i++)
        begin
            cyc(1);
            if (flash_busy_o === 1'b1)
                c++;
        end
    endtask
    task automatic pulse_done;
        sample_done_i = 1'b1;
        cyc(1);
        sample_done_i = 1'b0;
    endtask

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    initial
    begin
        #(25 * 20000);
        n_errors++;
        test_done();
    end

    initial
    begin
        void'($urandom(42));
        {nrst_i, sample_done_i, st_done_i, st_fail_i, alarm_pin_en_i, alarm_pin_val_i} = '0;
        misc_nv_i = {8'h01, 8'($urandom)};
        {dac_word_i, tilt_raw_i, sample_period_i, gpio_out_i} = {16'h0, 14'($urandom), 8'h10, 2'($urandom)};
        cyc(8);
        nrst_i = 1'b1;
        cyc(5);
        `CHK(misc_reg_o, exp_misc(misc_nv_i));
        // Zero bits, ignored bits and the upper byte trigger nothing
        for (int i = 0; i < 3; i++)
        begin
            host.wr(6'h3E + 6'(i / 2), i == 0 ? 8'h00 : (i == 1 ? 8'h60 : 8'hFF));
            `CHK({status_clr_o, soft_rst_o, flash_busy_o}, 0);
        end
        host.wr(GCM_ADDR_ACTION_LO, 8'h10);
        `CHK(status_clr_o, 1);
        cyc(1);
        `CHK(status_clr_o, 0);
        prev = dac_out_o;
        repeat (4)
        begin
            dac_word_i = 16'($urandom);
            host.wr(6'h30, dac_word_i[7:0]);
            host.wr(6'h31, dac_word_i[15:8], $urandom % 3);
            `CHK(dac_out_o, prev);
            host.wr(GCM_ADDR_ACTION_LO, 8'h04);
            `CHK(dac_out_o, dac_word_i[11:0]);
            prev = dac_out_o;
        end
        // Null, manual store, factory, then all three in one write
        for (int i = 0; i < 4; i++)
        begin
            cyc(6);
            host.wr(GCM_ADDR_ACTION_LO, i == 0 ? 8'h01 : (i == 1 ? 8'h08 : (i == 2 ? 8'h02 : 8'h0B)));
            store_len(n);
            `CHK(n, FLASH);
            if (i == 3)
            begin
                // Null and factory each end in a store of their own, one after the other
                store_len(n);
                `CHK(n, FLASH);
            end
            `CHK(tilt_offset_o, i < 2 ? 16'(tilt_raw_i) : 16'h0);
            if (i == 0)
                `CHK(tilt_out_o, 0);
            cyc(8);
            `CHK(flash_busy_o, 0);
        end
        for (int i = 0; i < 2; i++)
        begin
            host.wr(GCM_ADDR_MISC_HI, i == 0 ? 8'h02 : 8'h00);
            pulse_done();
            cyc(3);
            `CHK(tilt_out_o, exp_tilt(tilt_raw_i, i == 0));
        end
        host.wr(GCM_ADDR_MISC_HI, 8'h01);
        pulse_done();
        cyc(3);
        `CHK({tilt_out_o, sample_ovr_o, sample_period_o}, {GCM_ST_ANGLE, 1'b1, 8'h01});
        {st_done_i, st_fail_i} = 2'b11;
        cyc(1);
        st_done_i = 1'b0;
        cyc(1);
        `CHK(st_fail_o, 1);
        host.wr(GCM_ADDR_MISC_HI, 8'h00);
        cyc(3);
        `CHK({sample_ovr_o, sample_period_o}, {1'b0, sample_period_i});
        host.wr(GCM_ADDR_ACTION_LO, 8'h10);
        cyc(1);
        `CHK(st_fail_o, 0);
        // Data-ready on pin 1 over alarm; alarm owns pin 0 over general control
        {alarm_pin_en_i, alarm_pin_val_i} = {2'b11, 2'($urandom)};
        for (int i = 0; i < 2; i++)
        begin
            host.wr(GCM_ADDR_MISC_LO, i == 0 ? 8'h07 : 8'h05);
            repeat (3)
            begin
                pulse_done();
                cyc(39);
            end
            pulse_done();
            cyc(2);
            `CHK(pin_o, {i == 0, alarm_pin_val_i[0]});
            cyc(18);
            `CHK(pin_o[1], i != 0);
        end
        host.wr(GCM_ADDR_MISC_LO, 8'h00);
        alarm_pin_en_i = 2'b00;
        cyc(3);
        `CHK(pin_o, gpio_out_i);
        host.wr(GCM_ADDR_ACTION_LO, 8'h80);
        `CHK(soft_rst_o, 1);
        cyc(4);
        `CHK(misc_reg_o, exp_misc(misc_nv_i));
        test_done();
    end
endmodule
`default_nettype wire
